// *** src/sbt_pkg.sv ***
/*
  Package for the SRAM boundary scan test port: instruction codes,
  identification fields, chain lengths and the controller states.
  Assumes nothing of its surroundings.
*/
package sbt_pkg;

  // ----------------------------------------
  // Register sizes
  // ----------------------------------------
  localparam int unsigned IR_W = 3;
  localparam int unsigned BSR_LEN = 89;
  localparam int unsigned ID_W = 32;

  // ----------------------------------------
  // Instruction codes
  // ----------------------------------------
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INS_SAMPLE = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;

  // ----------------------------------------
  // Identification field positions and values (values arbitrary)
  // ----------------------------------------
  localparam int unsigned ID_REV_LSB = 29;
  localparam int unsigned ID_DEPTH_LSB = 24;
  localparam int unsigned ID_TYPE_LSB = 18;
  localparam int unsigned ID_DEV_LSB = 12;
  localparam int unsigned ID_MAKER_LSB = 1;
  localparam logic [2:0] ID_REV_VAL = 3'h0;
  localparam logic [4:0] ID_DEPTH_VAL = 5'h03;   // Arbitrary
  localparam logic [5:0] ID_TYPE_VAL = 6'h09;    // Arbitrary
  localparam logic [5:0] ID_DEV_VAL = 6'h11;     // Arbitrary
  localparam logic [10:0] ID_MAKER_VAL = 11'h05A; // Arbitrary
  localparam logic ID_PRESENT = 1'b1;

  // ----------------------------------------
  // Boundary cell positions and reset values
  // ----------------------------------------
  localparam int unsigned OE_CELL = 88;  // Cell #89, counted from one
  localparam logic [88:0] BSR_RESET = {1'b1, 88'h0};

  // ----------------------------------------
  // Controller states and pin carrier
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
    ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
    ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } sbt_state_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbt_pins_s;

endpackage : sbt_pkg

// *** src/sbt_tap.sv ***
/*
  Boundary scan test access port of the SRAM, sampled on ref_clk.
  Assumes the test pins come from the board, asynchronous to ref_clk,
  with a test clock much slower than ref_clk (bench uses 320 ns).
*/
// Overview of operation
// - Code 000 captures ring, selects boundary chain, forces SRAM outputs high-Z when the output control cell is low.
// - Code 001 loads the fixed identification value and selects it.
// - Code 010 captures ring, selects boundary chain, disables output drivers.
// - Code 100 captures ring, selects boundary chain, leaves memory untouched.
// - Code 111 selects the one-bit bypass register.
// - Boundary chain is exactly 89 cells long.
// - Identification bits 31:29 hold the revision.
// - Identification bits 28:24 hold a fixed depth field.
// - Identification bits 23:18 hold memory type and architecture.
// - Identification bits 17:12 hold the device identifier.
// - Identification bits 11:1 hold the maker code.
// - Identification bit 0 is always one.
// - Data sampled on test clock rise, data out changes on fall.
// - Reset and test-logic-reset load the identification instruction.
// - Capture-instruction loads 01 into the two low bits.
// - Output control cell presets high; low under EXTEST tristates outputs.
`timescale 1ns/1ns
`default_nettype none
module sbt_tap
  import sbt_pkg::*;
#(
  parameter int unsigned CHAIN_LEN = BSR_LEN
)(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire sbt_pins_s pins,
  input wire logic [CHAIN_LEN-1:0] ring_in,
  output logic tdo,
  output logic tdo_oe,
  output logic [CHAIN_LEN-1:0] ring_out,
  output logic sram_out_hiz
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  sbt_pins_s meta_q, sync_q, meta_d, sync_d;
  logic tck_old_q, tck_old_d;
  logic rise, fall;

  // Two stages before any logic looks at the pins
  always_comb
  begin
    meta_d = pins;
    sync_d = meta_q;
    tck_old_d = sync_q.tck;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Idle pin levels, so no false test clock edge follows reset
      meta_q <= '1;
      sync_q <= '1;
      tck_old_q <= 1'b1;
    end
    else if (clk_en)
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      tck_old_q <= tck_old_d;
    end
  end

  assign rise = sync_q.tck & ~tck_old_q;
  assign fall = ~sync_q.tck & tck_old_q;

  // ----------------------------------------
  // Controller state
  // ----------------------------------------
  sbt_state_e st_q, st_d;

  // Sixteen-state walk, mode bit taken at each test clock rise
  always_comb
  begin
    st_d = st_q;
    if (rise)
    begin
      unique case (st_q)
        ST_RESET: st_d = sync_q.tms ? ST_RESET : ST_IDLE;
        ST_IDLE: st_d = sync_q.tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: st_d = sync_q.tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: st_d = sync_q.tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR: st_d = sync_q.tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: st_d = sync_q.tms ? ST_UPD_DR : ST_PAU_DR;
        ST_PAU_DR: st_d = sync_q.tms ? ST_EX2_DR : ST_PAU_DR;
        ST_EX2_DR: st_d = sync_q.tms ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: st_d = sync_q.tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: st_d = sync_q.tms ? ST_RESET : ST_CAP_IR;
        ST_CAP_IR: st_d = sync_q.tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR: st_d = sync_q.tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: st_d = sync_q.tms ? ST_UPD_IR : ST_PAU_IR;
        ST_PAU_IR: st_d = sync_q.tms ? ST_EX2_IR : ST_PAU_IR;
        ST_EX2_IR: st_d = sync_q.tms ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: st_d = sync_q.tms ? ST_SEL_DR : ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= ST_RESET;
    else if (clk_en)
      st_q <= st_d;
  end

  // ----------------------------------------
  // Scan registers and instruction decode
  // ----------------------------------------
  logic [IR_W-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
  logic [ID_W-1:0] dr_id_q, dr_id_d;
  logic byp_q, byp_d;
  logic [CHAIN_LEN-1:0] bsr_q, bsr_d, upd_q, upd_d;
  logic tdo_q, tdo_d, oe_q, oe_d;
  logic sel_bsr, sel_id;
  logic in_reset;
  logic tick_cap_ir, tick_sh_ir, tick_upd_ir;
  logic tick_cap_dr, tick_sh_dr, tick_upd_dr;
  logic [ID_W-1:0] id_word;

  // Fixed identification word, field by field
  assign id_word = {ID_REV_VAL,
                    ID_DEPTH_VAL,
                    ID_TYPE_VAL,
                    ID_DEV_VAL,
                    ID_MAKER_VAL,
                    ID_PRESENT};

  // Reserved codes fall to bypass so the chain never breaks
  assign sel_bsr = (ir_q == INS_EXTEST) || (ir_q == INS_SAMPLE_Z)
                   || (ir_q == INS_SAMPLE);
  assign sel_id = (ir_q == INS_IDCODE);

  // Reset acts on the state itself, not on a later rise, so the
  // presets stand as soon as the controller arrives there
  assign in_reset = (st_q == ST_RESET);

  // One-cycle strobes: a test clock rise seen in the named state
  assign tick_cap_ir = rise && (st_q == ST_CAP_IR);
  assign tick_sh_ir = rise && (st_q == ST_SH_IR);
  assign tick_upd_ir = rise && (st_q == ST_UPD_IR);
  assign tick_cap_dr = rise && (st_q == ST_CAP_DR);
  assign tick_sh_dr = rise && (st_q == ST_SH_DR);
  assign tick_upd_dr = rise && (st_q == ST_UPD_DR);

  // ----------------------------------------
  // Instruction register
  // ----------------------------------------
  // Shift stage and held instruction; the held one moves only on
  // update or in reset, so a half-shifted code never reaches the decode
  always_comb
  begin
    ir_sh_d = ir_sh_q;
    ir_d = ir_q;
    if (tick_cap_ir)
      ir_sh_d = {ir_sh_q[IR_W-1:2], IR_CAPTURE_PAT};
    else if (tick_sh_ir)
      ir_sh_d = {sync_q.tdi, ir_sh_q[IR_W-1:1]};
    if (in_reset)
      ir_d = INS_IDCODE;
    else if (tick_upd_ir)
      ir_d = ir_sh_q;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ir_sh_q <= '0;
      ir_q <= INS_IDCODE;
    end
    else if (clk_en)
    begin
      ir_sh_q <= ir_sh_d;
      ir_q <= ir_d;
    end
  end

  // ----------------------------------------
  // Data registers
  // ----------------------------------------
  // Only the selected register captures or shifts; the ring is taken
  // as it stands, so a pin moving at capture may be caught either way
  always_comb
  begin
    dr_id_d = dr_id_q;
    byp_d = byp_q;
    bsr_d = bsr_q;
    if (tick_cap_dr)
    begin
      if (sel_bsr)
        bsr_d = ring_in;
      else if (sel_id)
        dr_id_d = id_word;
      else
        byp_d = 1'b0;
    end
    else if (tick_sh_dr)
    begin
      if (sel_bsr)
        bsr_d = {sync_q.tdi, bsr_q[CHAIN_LEN-1:1]};
      else if (sel_id)
        dr_id_d = {sync_q.tdi, dr_id_q[ID_W-1:1]};
      else
        byp_d = sync_q.tdi;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dr_id_q <= '0;
      byp_q <= 1'b0;
      bsr_q <= '0;
    end
    else if (clk_en)
    begin
      dr_id_q <= dr_id_d;
      byp_q <= byp_d;
      bsr_q <= bsr_d;
    end
  end

  // ----------------------------------------
  // Update latches
  // ----------------------------------------
  // Preload lands on update; test-logic-reset presets only the output control
  // cell, the rest keep what was last preloaded
  always_comb
  begin
    upd_d = upd_q;
    if (tick_upd_dr && sel_bsr)
      upd_d = bsr_q;
    if (in_reset)
      upd_d[OE_CELL] = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      upd_q <= BSR_RESET;
    else if (clk_en)
      upd_q <= upd_d;
  end

  // ----------------------------------------
  // Serial data out
  // ----------------------------------------
  // Data out changes only on test clock fall, driven in shift states;
  // the far end samples on rise, so half a test clock of margin
  always_comb
  begin
    tdo_d = tdo_q;
    oe_d = oe_q;
    if (fall)
    begin
      oe_d = (st_q == ST_SH_DR) || (st_q == ST_SH_IR);
      if (st_q == ST_SH_IR)
        tdo_d = ir_sh_q[0];
      else if (sel_bsr)
        tdo_d = bsr_q[0];
      else if (sel_id)
        tdo_d = dr_id_q[0];
      else
        tdo_d = byp_q;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tdo_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (clk_en)
    begin
      tdo_q <= tdo_d;
      oe_q <= oe_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Sample-Z always floats the bus; extest floats it when the cell is low
  assign sram_out_hiz = (ir_q == INS_SAMPLE_Z)
                        || ((ir_q == INS_EXTEST) && !upd_q[OE_CELL]);
  assign ring_out = upd_q;
  assign tdo = tdo_q;
  assign tdo_oe = oe_q;

endmodule : sbt_tap
`default_nettype wire

// *** tb/sbt_ctrl_model.sv ***
/* Board test controller model: drives the test pins and reads tdo.
   Assumes ref_clk at 25 MHz; one test clock lasts 8 ref_clk. */
`timescale 1ns/1ns
`default_nettype none
module sbt_ctrl_model
  import sbt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic tdo,
  output var sbt_pins_s pins
);
  // ----
  // Pin sequencing
  // ----
  // Test clock parks high between scans
  initial pins = '{tck: 1'b1, tms: 1'b1, tdi: 1'b0};

  // Fall, hold, rise, hold; tdo read late because of the sync lag
  task step(input logic ms, input logic di, output logic q);
    pins <= '{tck: 1'b0, tms: ms, tdi: di};
    repeat (4) @(posedge ref_clk);
    pins.tck <= 1'b1;
    repeat (4) @(posedge ref_clk);
    q = tdo;
  endtask : step

  // Idle, select, capture, n shifts, update, idle
  task scan(input logic ir, input int n, input logic [88:0] din, output logic [88:0] dout);
    logic q;
    dout = '0;
    step(1'b0, 1'b0, q);
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : scan

  // Five highs reach the reset state from anywhere
  task reset5;
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
  endtask : reset5
endmodule : sbt_ctrl_model
`default_nettype wire

// *** tb/sbt_tap_monitor.sv ***
/* Checker for the SRAM test port, bound into sbt_tap.
   Assumes a test clock far slower than ref_clk. */
`timescale 1ns/1ns
`default_nettype none
module sbt_tap_monitor
  import sbt_pkg::*;
#(
  parameter int unsigned CHAIN_LEN = BSR_LEN
)(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire sbt_pins_s pins,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [CHAIN_LEN-1:0] ring_out,
  input wire logic sram_out_hiz
);
  // ----
  // Properties
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Test clock level two samples back, past the synchroniser
  sequence s_fell; !$past(pins.tck, 2); endsequence
  sequence s_rose; $past(pins.tck, 2); endsequence

  a_reset_values: assert property ($rose(reset_n) |-> ring_out[OE_CELL] && !tdo_oe && !sram_out_hiz)
    else $error("reset values wrong");
  a_tdo_on_fall: assert property ($changed(tdo) |-> s_fell)
    else $error("tdo moved off a falling test clock");
  a_oe_on_fall: assert property ($changed(tdo_oe) |-> s_fell)
    else $error("tdo enable moved off a falling test clock");
  a_ring_on_rise: assert property ($changed(ring_out) |-> s_rose)
    else $error("ring out moved off a rising test clock");
  a_hiz_on_rise: assert property ($changed(sram_out_hiz) |-> s_rose)
    else $error("high-z moved off a rising test clock");
  a_oe_stands: assert property ($rose(tdo_oe) |=> tdo_oe [*6])
    else $error("tdo enable too short");
  a_tdo_stands: assert property ($changed(tdo) |=> $stable(tdo) [*6])
    else $error("tdo not held");
  a_ring_stands: assert property ($changed(ring_out) |=> $stable(ring_out) [*6])
    else $error("ring out not held");
endmodule : sbt_tap_monitor

bind sbt_tap sbt_tap_monitor #(.CHAIN_LEN(CHAIN_LEN)) u_mon (.ref_clk(ref_clk),
  .reset_n(reset_n), .pins(pins), .tdo(tdo), .tdo_oe(tdo_oe), .ring_out(ring_out),
  .sram_out_hiz(sram_out_hiz));
`default_nettype wire

// *** tb/tb_sram_boundary_scan_tap.sv ***
/* Self-checking bench for the SRAM test port.
   Assumes the controller model and checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb_sram_boundary_scan_tap
  import sbt_pkg::*;
;
  // ----
  // Bench signals
  // ----
  localparam logic [88:0] PAT = 89'hff_0000_a5a5_5a5a_1234_5678;
  localparam logic [88:0] PRE = 89'h0_dead_beef_0000_cafe_0001;
  localparam logic [88:0] ID_EXP = 89'({ID_REV_VAL, ID_DEPTH_VAL, ID_TYPE_VAL, ID_DEV_VAL,
    ID_MAKER_VAL, ID_PRESENT});
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [88:0] ring_in = 89'h0;
  sbt_pins_s pins;
  logic tdo, tdo_oe, sram_out_hiz;
  logic [88:0] ring_out, got;
  int fails = 0;
  int n_compared = 0;

  // Clock enable dropped only by the freeze test
  sbt_tap dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .pins(pins),
    .ring_in(ring_in), .tdo(tdo), .tdo_oe(tdo_oe), .ring_out(ring_out),
    .sram_out_hiz(sram_out_hiz));
  sbt_ctrl_model u_ctl (.ref_clk(ref_clk), .tdo(tdo), .pins(pins));

  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end

  task chk(input string what, input logic [88:0] exp, input logic [88:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  task t_idcode;
    u_ctl.scan(1'b0, 32, 89'h0, got);
    chk("idcode", ID_EXP, got);
    chk("tdo released", 89'h0, 89'(tdo_oe));
    u_ctl.scan(1'b1, 3, 89'(INS_IDCODE), got);
    chk("ir capture", 89'h1, 89'(got[1:0]));
    $display("test idcode done");
  endtask : t_idcode

  task t_bypass;
    u_ctl.scan(1'b1, 3, 89'(INS_BYPASS), got);
    u_ctl.scan(1'b0, 3, 89'h6, got);
    chk("bypass", 89'h4, got);
    $display("test bypass done");
  endtask : t_bypass

  // Cell 89 preloaded low; must not tristate outside the tristating codes
  task t_sample;
    ring_in <= PAT;
    u_ctl.scan(1'b1, 3, 89'(INS_SAMPLE), got);
    u_ctl.scan(1'b0, 89, PRE, got);
    chk("sample", PAT, got);
    chk("preload", PRE, ring_out);
    chk("hiz sample", 89'h0, 89'(sram_out_hiz));
    $display("test sample done");
  endtask : t_sample

  // Frozen port must ignore a whole instruction scan
  task t_freeze;
    clk_en <= 1'b0;
    u_ctl.scan(1'b1, 3, 89'(INS_BYPASS), got);
    clk_en <= 1'b1;
    chk("freeze ring", PRE, ring_out);
    u_ctl.scan(1'b0, 89, PRE, got);
    chk("freeze sample", PAT, got);
    $display("test freeze done");
  endtask : t_freeze

  task t_extest;
    u_ctl.scan(1'b1, 3, 89'(INS_EXTEST), got);
    chk("hiz extest", 89'h1, 89'(sram_out_hiz));
    u_ctl.scan(1'b0, 89, {1'b1, 88'h0}, got);
    chk("extest capture", PAT, got);
    chk("hiz cell high", 89'h0, 89'(sram_out_hiz));
    u_ctl.scan(1'b1, 3, 89'(INS_SAMPLE_Z), got);
    chk("hiz sample z", 89'h1, 89'(sram_out_hiz));
    u_ctl.scan(1'b0, 89, 89'h0, got);
    chk("sample z capture", PAT, got);
    $display("test extest done");
  endtask : t_extest

  task t_tlr;
    u_ctl.reset5;
    // Let the presets settle before looking
    repeat (2) @(posedge ref_clk);
    chk("tlr preset", {1'b1, 88'h0}, ring_out);
    chk("hiz tlr", 89'h0, 89'(sram_out_hiz));
    u_ctl.scan(1'b0, 32, 89'h0, got);
    chk("idcode tlr", ID_EXP, got);
    $display("test tlr done");
  endtask : t_tlr

  task results;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_idcode;
    t_bypass;
    t_sample;
    t_freeze;
    t_extest;
    t_tlr;
    results;
  end

  // Tests need about 4250 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    results;
  end
endmodule : tb_sram_boundary_scan_tap
`default_nettype wire
